// >>> fpi_top.sv
// front panel lamp driver with avalon register slave
// Functional notes
// R1 - flash the activity lamp on any host interface traffic
// R2 - fault lamp lit while queue overrun, run or syntax fault latched
// R3 - clearing those event flags by command switches the fault lamp off
// R4 - mixer power lamp follows the two unlatched overdrive flags
// R5 - loop unlock lamp follows error low or error high flag
// R6 - trim lamp lit exactly while the trim input is enabled
// R7 - offset lamp lit exactly while the offset input is enabled
// R8 - probe selection is held until the host changes it
// R9 - lamps are registered each cycle; activity flash is stretched
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module fpi_top #(
   parameter int FLASH_CYCLES = fpi_pkg::FLASH_CYCLES
) (
   input wire logic clk_i, // 10 mhz clock
   input wire logic sys_rst_i, // async reset, high
   input wire logic [3:0] avs_address_i, // word address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [31:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // byte lanes
   output logic [31:0] avs_readdata_o, // read data
   output logic avs_waitrequest_o, // stall
   input wire logic host_rx_i, // byte received from host
   input wire logic host_tx_i, // byte sent to host
   input wire logic queue_overrun_i, // input queue overrun event
   input wire logic run_fault_i, // command run fault event
   input wire logic syntax_fault_i, // command syntax event
   input wire logic clear_status_i, // clear status command run
   input wire fpi_pkg::fpi_overload_t overload_i, // live overload flags
   output fpi_pkg::fpi_lamps_t lamps_o, // lamp drives
   output logic [2:0] probe_sel_o, // probe output source
   output logic irq_o // event interrupt
);
   logic [fpi_pkg::EVT_W-1:0] evt_r;
   logic [fpi_pkg::EVT_W-1:0] mask_r;
   logic [fpi_pkg::EVT_W-1:0] evt_set;
   logic [fpi_pkg::EVT_W-1:0] evt_clr;
   logic trim_en_r;
   logic offset_en_r;
   logic [fpi_pkg::PROBE_W-1:0] probe_r;
   logic acc_r;
   logic wr_go;
   logic rd_go;
   logic flash;
   logic [31:0] rd_nxt;

   // one wait cycle per access: request is taken when waitrequest drops
   // acc_r marks the second cycle of a request, the one in which the
   // master sees waitrequest low; writes land only there, so a request
   // held for two edges is never applied twice
   // the trade is a fixed two-cycle access even for a plain read, which
   // keeps the read mux out of the path to the readdata pins
   assign wr_go = avs_write_i && acc_r;
   assign rd_go = avs_read_i && acc_r;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         acc_r <= 1'b0;
      end else begin
         acc_r <= (avs_read_i || avs_write_i) && !acc_r;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !acc_r);
      end
   end

   // event sources; bus clear is write one to clear
   // the clear command wipes all three flags at once, while a bus write
   // clears only the bits written as one, so software can acknowledge
   // one fault kind and leave the others lit
   assign evt_set = {syntax_fault_i, run_fault_i, queue_overrun_i};
   always_comb begin
      evt_clr = '0;
      if (clear_status_i) begin
         evt_clr = '1; // R3
      end
      if (wr_go && avs_address_i == fpi_pkg::ADDR_EVT_STATUS
          && avs_byteenable_i[0]) begin
         evt_clr = evt_clr | avs_writedata_i[fpi_pkg::EVT_W-1:0];
      end
   end

   // set wins over clear so an event in the clearing cycle survives
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         evt_r <= fpi_pkg::EVT_RESET;
      end else begin
         evt_r <= (evt_r & ~evt_clr) | evt_set; // R2 R3
      end
   end

   // mask and control writes
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mask_r <= fpi_pkg::EVT_RESET;
      end else if (wr_go && avs_address_i == fpi_pkg::ADDR_EVT_MASK
                   && avs_byteenable_i[0]) begin
         mask_r <= avs_writedata_i[fpi_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trim_en_r <= 1'b0;
         offset_en_r <= 1'b0;
         probe_r <= fpi_pkg::PROBE_RESET;
      end else if (wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL
                   && avs_byteenable_i[0]) begin
         trim_en_r <= avs_writedata_i[fpi_pkg::CTL_TRIM]; // R6
         offset_en_r <= avs_writedata_i[fpi_pkg::CTL_OFFSET]; // R7
         probe_r <= avs_writedata_i[fpi_pkg::CTL_PROBE_LSB +:
                                    fpi_pkg::PROBE_W]; // R8
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_nxt = 32'h0;
      unique case (avs_address_i)
         fpi_pkg::ADDR_EVT_STATUS: rd_nxt[fpi_pkg::EVT_W-1:0] = evt_r;
         fpi_pkg::ADDR_EVT_MASK: rd_nxt[fpi_pkg::EVT_W-1:0] = mask_r;
         fpi_pkg::ADDR_CONTROL: begin
            rd_nxt[fpi_pkg::CTL_TRIM] = trim_en_r;
            rd_nxt[fpi_pkg::CTL_OFFSET] = offset_en_r;
            rd_nxt[fpi_pkg::CTL_PROBE_LSB +: fpi_pkg::PROBE_W] = probe_r;
         end
         fpi_pkg::ADDR_LAMPS: rd_nxt[5:0] = lamps_o;
         fpi_pkg::ADDR_OVERLOAD: rd_nxt[3:0] = overload_i;
         default: rd_nxt = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         avs_readdata_o <= 32'h0;
      end else if ((avs_read_i || avs_write_i) && !acc_r) begin
         avs_readdata_o <= rd_nxt;
      end
   end

   // activity stretcher
   fpi_stretch #(
      .CYCLES(FLASH_CYCLES),
      .CW(fpi_pkg::FLASH_CW)
   ) u_flash (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .trig_i(host_rx_i || host_tx_i), // R1 R9
      .on_o(flash)
   );

   // registered lamps, refreshed every cycle
   // the overload lamps follow live flags with one cycle of lag; there
   // is no latching here, so a short overdrive may light a lamp for a
   // single cycle only, too short to be seen without the host reading
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lamps_o <= '0;
      end else begin
         lamps_o.host_activity_lamp <= flash; // R1
         lamps_o.host_fault_lamp <= |evt_r; // R2 R9
         lamps_o.mixer_power_lamp <= overload_i.signal_port_overdrive_flag
            || overload_i.local_osc_overdrive_flag; // R4
         lamps_o.loop_unlock_lamp <= overload_i.error_low_flag
            || overload_i.error_high_flag; // R5
         lamps_o.trim_input_lamp <= trim_en_r; // R6
         lamps_o.offset_enabled_lamp <= offset_en_r; // R7
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         probe_sel_o <= fpi_pkg::PROBE_RESET;
         irq_o <= 1'b0;
      end else begin
         probe_sel_o <= probe_r; // R8
         irq_o <= |(evt_r & mask_r);
      end
   end

   // checks
   a_fault_lamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 lamps_o.host_fault_lamp == |$past(evt_r)) // R2
      else $error("fault lamp wrong");
   a_clear_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      clear_status_i && !(|evt_set) |-> ##2 !lamps_o.host_fault_lamp) // R3
      else $error("fault lamp not cleared");
   a_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      queue_overrun_i |=> evt_r[fpi_pkg::EVT_QUEUE_OVR]) // R2
      else $error("event lost");
   a_mixer_lamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      overload_i.signal_port_overdrive_flag |=> lamps_o.mixer_power_lamp)
      // R4
      else $error("mixer lamp wrong");
   a_mixer_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !overload_i.signal_port_overdrive_flag
      && !overload_i.local_osc_overdrive_flag
      |=> !lamps_o.mixer_power_lamp) // R4
      else $error("mixer lamp stuck");
   a_unlock_lamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 lamps_o.loop_unlock_lamp == ($past(overload_i.error_low_flag)
      || $past(overload_i.error_high_flag))) // R5
      else $error("unlock lamp wrong");
   a_trim_lamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 lamps_o.trim_input_lamp == $past(trim_en_r)) // R6
      else $error("trim lamp wrong");
   a_offset_lamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 lamps_o.offset_enabled_lamp == $past(offset_en_r)) // R7
      else $error("offset lamp wrong");
   a_probe_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL)
      |=> $stable(probe_r)) // R8
      else $error("probe select moved");
   a_flash_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      host_rx_i || host_tx_i |-> ##2 lamps_o.host_activity_lamp[*2]) // R1
      else $error("activity lamp did not flash");
   a_bus_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) // R9
      else $error("bus answer late");

   // register write effects, one cycle after the accepted write
   a_trim_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL
      && avs_byteenable_i[0]
      |=> trim_en_r == $past(avs_writedata_i[fpi_pkg::CTL_TRIM])) // R6
      else $error("trim enable not written");
   a_offset_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL
      && avs_byteenable_i[0]
      |=> offset_en_r == $past(avs_writedata_i[fpi_pkg::CTL_OFFSET])) // R7
      else $error("offset enable not written");
   a_probe_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL
      && avs_byteenable_i[0]
      |=> probe_r == $past(avs_writedata_i[fpi_pkg::CTL_PROBE_LSB +:
                                           fpi_pkg::PROBE_W])) // R8
      else $error("probe select not written");

   // settings hold between writes to their own register
   a_trim_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL)
      |=> $stable(trim_en_r)) // R6
      else $error("trim enable moved");
   a_offset_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL)
      |=> $stable(offset_en_r)) // R7
      else $error("offset enable moved");
   a_mask_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(wr_go && avs_address_i == fpi_pkg::ADDR_EVT_MASK)
      |=> $stable(mask_r)) // R2
      else $error("mask moved");
   a_probe_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 probe_sel_o == $past(probe_r)) // R8
      else $error("probe output lags");

   // event flags: sticky until cleared, cleared by command or write one
   a_evt_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(|evt_clr) |=> ($past(evt_r) & ~evt_r) == '0) // R2
      else $error("event flag dropped");
   a_clear_evt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      clear_status_i && !(|evt_set) |=> evt_r == '0) // R3
      else $error("clear command left a flag");
   a_w1c_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go && avs_address_i == fpi_pkg::ADDR_EVT_STATUS
      && avs_byteenable_i[0] && !(|evt_set)
      |=> (evt_r & $past(avs_writedata_i[fpi_pkg::EVT_W-1:0])) == '0) // R3
      else $error("write one did not clear");
   a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 irq_o == |($past(evt_r) & $past(mask_r))) // R2
      else $error("interrupt level wrong");

   // the second overdrive flag and the error low flag light their lamps too
   a_lo_lamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      overload_i.local_osc_overdrive_flag |=> lamps_o.mixer_power_lamp)
      // R4
      else $error("mixer lamp missed lo overdrive");
   a_low_lamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      overload_i.error_low_flag |=> lamps_o.loop_unlock_lamp) // R5
      else $error("unlock lamp missed low error");

   // bus slave timing
   a_bus_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !avs_read_i && !avs_write_i |=> avs_waitrequest_o) // R9
      else $error("waitrequest low while idle");
   a_write_once: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go |=> !wr_go) // R9
      else $error("write applied twice");
   a_read_data: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_go |-> avs_readdata_o == $past(rd_nxt)) // R9
      else $error("read data not from the request cycle");
   a_rdata_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !avs_read_i && !avs_write_i |=> $stable(avs_readdata_o)) // R9
      else $error("read data moved while idle");

   // scenario covers
   c_unlock: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(lamps_o.loop_unlock_lamp));
   c_fault: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      lamps_o.host_fault_lamp ##1 clear_status_i ##2
      !lamps_o.host_fault_lamp);
   c_flash: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      host_tx_i ##2 lamps_o.host_activity_lamp);
   c_probe: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go && avs_address_i == fpi_pkg::ADDR_CONTROL);
   c_irq: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(irq_o));
endmodule // fpi_top

// >>> fpi_pkg.sv
// package for the front panel status indicator block
package fpi_pkg;
   // register word addresses
   localparam logic [3:0] ADDR_EVT_STATUS = 4'h0;
   localparam logic [3:0] ADDR_EVT_MASK = 4'h1;
   localparam logic [3:0] ADDR_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_LAMPS = 4'h3;
   localparam logic [3:0] ADDR_OVERLOAD = 4'h4;
   // event status field positions
   localparam int EVT_QUEUE_OVR = 0;
   localparam int EVT_RUN_FAULT = 1;
   localparam int EVT_SYNTAX = 2;
   localparam int EVT_W = 3;
   // control field positions
   localparam int CTL_TRIM = 0;
   localparam int CTL_OFFSET = 1;
   localparam int CTL_PROBE_LSB = 4;
   localparam int PROBE_W = 3;
   // reset values
   localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
   localparam logic [PROBE_W-1:0] PROBE_RESET = 3'h0;
   // activity flash duration
   localparam int CLK_HZ = 10_000_000;
   localparam int FLASH_MS = 50;
   localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
   localparam int FLASH_CW = 20;

   // overload flags as they arrive from the analog monitors
   typedef struct packed {
      logic signal_port_overdrive_flag;
      logic local_osc_overdrive_flag;
      logic error_low_flag;
      logic error_high_flag;
   } fpi_overload_t;

   // lamps driven to the front panel
   typedef struct packed {
      logic host_activity_lamp;
      logic host_fault_lamp;
      logic mixer_power_lamp;
      logic loop_unlock_lamp;
      logic trim_input_lamp;
      logic offset_enabled_lamp;
   } fpi_lamps_t;
endpackage

// >>> fpi_stretch.sv
// pulse stretcher for the activity lamp
`timescale 1ns/10ps
module fpi_stretch #(
   parameter int CYCLES = 500000,
   parameter int CW = 20
) (
   input wire logic clk_i, // clock
   input wire logic sys_rst_i, // async reset
   input wire logic trig_i, // transfer seen
   output logic on_o // stretched output
);
   logic [CW-1:0] cnt_r;

   // retrigger reloads, so steady traffic keeps the lamp lit
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= '0;
      end else if (trig_i) begin
         cnt_r <= CW'(CYCLES);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         on_o <= 1'b0;
      end else begin
         on_o <= trig_i || (cnt_r > CW'(1));
      end
   end
endmodule // fpi_stretch

// >>> fpi_host_model.sv
// host side model: traffic strobes, command faults and clears
`timescale 1ns/10ps
module fpi_host_model (
   input wire logic clk_i, // clock
   output logic rx_o, // byte from host
   output logic tx_o, // byte to host
   output logic [2:0] evt_o, // syntax, run, queue faults
   output logic clr_o // clear status command run
);
   // quiet between commands so stale strobes never linger
   initial begin
      {clr_o, tx_o, rx_o, evt_o} = 6'h00;
   end
   // m = {clear, tx, rx, syntax, run, queue}, one cycle wide
   task automatic pulse(input logic [5:0] m);
      @(posedge clk_i);
      {clr_o, tx_o, rx_o, evt_o} <= m;
      @(posedge clk_i);
      {clr_o, tx_o, rx_o, evt_o} <= 6'h00;
   endtask
endmodule // fpi_host_model

// >>> test_front_panel_status_indicators.sv
// self-checking bench for the front panel lamp driver
`timescale 1ns/10ps
module test_front_panel_status_indicators;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, rx, tx, clr, irq_o;
   logic [2:0] evt, probe_sel_o;
   fpi_pkg::fpi_overload_t overload_i = 4'h0;
   fpi_pkg::fpi_lamps_t lamps_o;
   int mismatches = 0;
   int checked = 0;
   integer seed = 32'ha4a68ba0;
   logic [35:0] notes[$];
   logic [35:0] n;
   logic fault_e = 1'b0;
   logic [6:0] ctl_e = 7'h00;
   logic [31:0] d;

   fpi_host_model host (.clk_i(clk_i), .rx_o(rx), .tx_o(tx), .evt_o(evt),
      .clr_o(clr));
   // short flash keeps the activity checks quick
   fpi_top #(.FLASH_CYCLES(8)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .host_rx_i(rx),
      .host_tx_i(tx), .queue_overrun_i(evt[0]), .run_fault_i(evt[1]),
      .syntax_fault_i(evt[2]), .clear_status_i(clr),
      .overload_i(overload_i), .lamps_o(lamps_o),
      .probe_sel_o(probe_sel_o), .irq_o(irq_o));

   // 100 ns period
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic close_out();
      if (mismatches == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // one avalon cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      do begin
         @(posedge clk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 20);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      if (k >= 20) begin
         chk("waitrequest", {31'h0, avs_waitrequest_o}, 32'h0);
         close_out();
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      notes.push_back({a, e});
      bus(1'b0, a, 32'h0);
   endtask

   // lamp word as the flags and settings should light it
   function automatic logic [31:0] lamp_e(input logic act);
      return {26'h0, act, fault_e, overload_i[3] | overload_i[2],
         overload_i[1] | overload_i[0], ctl_e[0], ctl_e[1]};
   endfunction

   // oldest note is compared at the edge the slave answers
   always @(posedge clk_i) begin
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
         n = notes.size() > 0 ? notes.pop_front() : 36'hx;
         chk($sformatf("reg %h", n[35:32]), avs_readdata_o, n[31:0]);
      end
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) rd(i[3:0], 32'h0);
      bus(1'b1, 4'hf, 32'hffffffff);
      rd(4'hf, 32'h0);
      // enables and probe source, random settings
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         ctl_e = d[6:0] & 7'h73;
         bus(1'b1, 4'h2, d);
         rd(4'h2, {25'h0, ctl_e});
         rd(4'h3, lamp_e(1'b0));
         chk("probe", {29'h0, probe_sel_o}, {29'h0, ctl_e[6:4]});
      end
      // every overload combination
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_i);
         overload_i <= i[3:0];
         rd(4'h4, {28'h0, i[3:0]});
         rd(4'h3, lamp_e(1'b0));
      end
      bus(1'b1, 4'h1, 32'h7);
      // each fault kind, then a clear command
      for (int k = 0; k < 3; k++) begin
         host.pulse(6'h01 << k);
         fault_e = 1'b1;
         rd(4'h0, 32'h1 << k);
         rd(4'h3, lamp_e(1'b0));
         chk("irq", {31'h0, irq_o}, 32'h1);
         host.pulse(6'h20);
         fault_e = 1'b0;
         rd(4'h0, 32'h0);
         rd(4'h3, lamp_e(1'b0));
         chk("irq", {31'h0, irq_o}, 32'h0);
      end
      // partial write-one clear keeps the lamp lit
      host.pulse(6'h07);
      fault_e = 1'b1;
      bus(1'b1, 4'h0, 32'h2);
      rd(4'h0, 32'h5);
      rd(4'h3, lamp_e(1'b0));
      bus(1'b1, 4'h0, 32'h5);
      fault_e = 1'b0;
      rd(4'h3, lamp_e(1'b0));
      // receive then send traffic, flash then dark
      for (int k = 0; k < 2; k++) begin
         host.pulse(6'h08 << k);
         rd(4'h3, lamp_e(1'b1));
         repeat (20) @(posedge clk_i);
         rd(4'h3, lamp_e(1'b0));
      end
      repeat (3) @(posedge clk_i);
      close_out();
   end
endmodule // test_front_panel_status_indicators
